// >>> rtl/gcr_cmd_if.sv
// Interface carrying byte events from the decoder to the core.
// Assumes a single clock domain; no clocking block.
`timescale 1ns/100ps
interface gcr_cmd_if;
  logic swreset; // One-cycle software reset pulse
  logic ack;     // Level: acknowledge requested for current byte
  modport dec (output swreset, output ack);
  modport core (input swreset, input ack);
endinterface

// >>> rtl/gcr_core.sv
// Behaviour
// RULE1: Acknowledge general call address zero.
// RULE2: Evaluate byte following general call.
// RULE3: Command 06h requests software reset.
// RULE4: Software reset restores power-on register values.
// RULE5: Software reset aborts running conversion.
// RULE6: Other command bytes change nothing.
// RULE7: Sample supply-valid throughout each conversion.
// RULE8: No conversion while supply invalid.
// RULE9: Invalid supply sets result bit one.
// RULE10: Open sensor sets result bit zero.
// RULE11: Reset after ack; supply bit refreshed per attempt.
//
// Top of the block: general call reset and supply-valid gating.
// Assumes the serial front end hands over received bytes, and that
// supply and sensor comparator levels arrive asynchronously.
`timescale 1ns/100ps
module gcr_core
(
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       byte_valid_i,
  input  wire logic       first_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       supply_ok_i,
  input  wire logic       sensor_open_i,
  input  wire logic       conv_start_i,
  output logic            gc_ack_o,
  output logic            swreset_o,
  output logic            converting_o,
  output logic            conv_done_o,
  output logic [1:0]      local_status_o,
  output logic [1:0]      remote_status_o
);
  `include "gcr_params.svh"
  gcr_cmd_if cmd ();                 // Decoder to core events
  // Decoder instance
  gcr_gcall_dec u_dec
  (
    .mclk_i       (mclk_i),
    .rst_i        (rst_i),
    .byte_valid_i (byte_valid_i),
    .first_i      (first_i),
    .byte_i       (byte_i),
    .cmd          (cmd)
  );
  // Three-stage synchronisers; stage 1 read only by stage 2
  // Chain resets to 0, which reads as bad supply, so no start
  // can slip through before the chain has settled
  logic [2:0] sup_s_q;               // Supply-valid chain
  logic [2:0] opn_s_q;               // Open-sensor chain
  logic       sup_q;                 // Filtered supply level
  logic       opn_q;                 // Filtered open level
  logic       sw_rst;                // Combined reset term
  assign sw_rst = rst_i || cmd.swreset; // [RULE4]
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      sup_s_q <= 3'h0;
      opn_s_q <= 3'h0;
      sup_q   <= 1'b0;
      opn_q   <= 1'b0;
    end
    else
    begin
      sup_s_q <= {sup_s_q[1:0], supply_ok_i};
      opn_s_q <= {opn_s_q[1:0], sensor_open_i};
      if (sup_s_q[1] == sup_s_q[2])
        sup_q <= sup_s_q[2]; // Change counts when stages agree
      if (opn_s_q[1] == opn_s_q[2])
        opn_q <= opn_s_q[2];
    end
  end
  // Conversion engine
  // Abort and power-on share one reset term, so a reset command
  // can never leave a half-run attempt behind
  // Trade-off: the decoder is not cleared by the command,
  // so a general call right after it is still decoded
  gcr_pkg::gcr_conv_t conv_q;        // Engine state
  logic [15:0]        cnt_q;         // Cycles remaining
  logic               sup_bad_q;     // Supply dropped in this attempt
  logic               opn_hit_q;     // Open seen in this attempt
  logic               start_ok;      // Start allowed
  logic               finish;        // Last conversion cycle
  logic [1:0]         res_status;    // Status bits at attempt end
  // Start needs idle engine, a request and a settled good supply
  assign start_ok = (conv_q == gcr_pkg::GCR_CONV_IDLE) && conv_start_i && sup_q; // [RULE8]
  assign finish   = (conv_q == gcr_pkg::GCR_CONV_RUN) && ((cnt_q == 16'h0001) || !sup_q);
  assign res_status[`GCR_SUPPLY_BIT] = sup_bad_q || !sup_q; // [RULE9]
  assign res_status[`GCR_OPEN_BIT]   = opn_hit_q || opn_q;  // [RULE10]
  // Engine sequencing; reset command aborts any run
  always_ff @(posedge mclk_i)
  begin
    if (sw_rst)
    begin
      conv_q    <= gcr_pkg::GCR_CONV_IDLE; // [RULE5]
      cnt_q     <= 16'h0000;
      sup_bad_q <= 1'b0;
      opn_hit_q <= 1'b0;
    end
    else
    begin
      case (conv_q)
        gcr_pkg::GCR_CONV_IDLE:
        begin
          if (start_ok)
          begin
            conv_q    <= gcr_pkg::GCR_CONV_RUN;
            cnt_q     <= `GCR_CONV_CYCLES;
            sup_bad_q <= 1'b0;
            opn_hit_q <= 1'b0;
          end
        end
        gcr_pkg::GCR_CONV_RUN:
        begin
          sup_bad_q <= sup_bad_q || !sup_q; // Watched every cycle [RULE7]
          opn_hit_q <= opn_hit_q || opn_q;  // [RULE10]
          cnt_q     <= cnt_q - 16'h0001;
          if (finish)
            conv_q  <= gcr_pkg::GCR_CONV_IDLE; // Invalid supply ends it [RULE8]
        end
        default:
          conv_q <= gcr_pkg::GCR_CONV_IDLE;
      endcase
    end
  end
  // Result status and outputs; refusal of a start also refreshes bit 1
  // Local bit 0 stays 0: there is no sensor wire to open locally
  logic refused;                     // Start refused for bad supply
  assign refused = (conv_q == gcr_pkg::GCR_CONV_IDLE) && conv_start_i && !sup_q;
  always_ff @(posedge mclk_i)
  begin
    if (sw_rst)
    begin
      local_status_o  <= 2'(`GCR_RESULT_RST); // Power-on values [RULE4]
      remote_status_o <= 2'(`GCR_RESULT_RST);
      conv_done_o     <= 1'b0;
      converting_o    <= 1'b0;
    end
    else
    begin
      conv_done_o  <= finish;
      converting_o <= ((conv_q == gcr_pkg::GCR_CONV_RUN) && !finish) || start_ok;
      if (finish)
      begin
        local_status_o  <= {res_status[`GCR_SUPPLY_BIT], 1'b0}; // [RULE11]
        remote_status_o <= res_status; // [RULE9]
      end
      else if (refused)
      begin
        local_status_o[`GCR_SUPPLY_BIT]  <= 1'b1; // [RULE9]
        remote_status_o[`GCR_SUPPLY_BIT] <= 1'b1;
      end
    end
  end
  // Bus-facing flags registered straight out
  // Only the pin reset clears these, so the reset pulse itself
  // still reaches the output after the core has been cleared
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      gc_ack_o  <= 1'b0;
      swreset_o <= 1'b0;
    end
    else
    begin
      gc_ack_o  <= cmd.ack;     // [RULE1]
      swreset_o <= cmd.swreset; // [RULE3]
    end
  end
  // Checks
  chk_no_start_bad: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!sup_q && !cmd.swreset && conv_q == gcr_pkg::GCR_CONV_IDLE) |=> conv_q == gcr_pkg::GCR_CONV_IDLE) // [RULE8]
    else $error("conversion started on bad supply");
  chk_reset_abort: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd.swreset |=> conv_q == gcr_pkg::GCR_CONV_IDLE && remote_status_o == 2'h0) // [RULE5]
    else $error("reset did not abort");
  chk_reset_out: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd.swreset |=> swreset_o) // [RULE3]
    else $error("reset pulse not forwarded");
  chk_supply_bit: assert property (@(posedge mclk_i) disable iff (rst_i)
    (finish && !sup_q && !cmd.swreset) |=> remote_status_o[1] && local_status_o[1]) // [RULE9]
    else $error("supply bit not set");
  chk_open_bit: assert property (@(posedge mclk_i) disable iff (rst_i)
    (finish && opn_q && !cmd.swreset) |=> remote_status_o[0]) // [RULE10]
    else $error("open bit not set");
  chk_supply_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
    (finish && !res_status[1] && !cmd.swreset) |=> !remote_status_o[1]) // [RULE11]
    else $error("supply bit not refreshed");
  chk_gc_ack: assert property (@(posedge mclk_i) disable iff (rst_i)
    (byte_valid_i && first_i && byte_i == 8'h00) |=> ##1 gc_ack_o) // [RULE1]
    else $error("general call not acknowledged");
  chk_other_cmd: assert property (@(posedge mclk_i) disable iff (rst_i)
    (byte_valid_i && !first_i && byte_i != 8'h06) |=> !cmd.swreset) // [RULE6]
    else $error("other command acted");
  chk_run_bound: assert property (@(posedge mclk_i) disable iff (rst_i)
    start_ok |=> ##[1:70] conv_q == gcr_pkg::GCR_CONV_IDLE) // [RULE7]
    else $error("conversion ran too long");
  cov_reset: cover property (@(posedge mclk_i) cmd.swreset && conv_q == gcr_pkg::GCR_CONV_RUN);
  cov_done: cover property (@(posedge mclk_i) finish && sup_q);
  cov_refused: cover property (@(posedge mclk_i) refused);
  // Scenario coverage: open sensor and early end on supply loss
  cov_open: cover property (@(posedge mclk_i) finish && opn_q);
  cov_sup_drop: cover property (@(posedge mclk_i) finish && !sup_q && (cnt_q != 16'h0001));
  // Guards on pulse width, refusals, supply loss, local open bit and accepted starts
  chk_supply_drop: assert property (@(posedge mclk_i) disable iff (rst_i)
    (conv_q == gcr_pkg::GCR_CONV_RUN && !sup_q && !cmd.swreset) |=> conv_q == gcr_pkg::GCR_CONV_IDLE) // [RULE7]
    else $error("supply loss did not end conversion");
  chk_refuse_flag: assert property (@(posedge mclk_i) disable iff (rst_i)
    (refused && !cmd.swreset) |=> local_status_o[1] && remote_status_o[1]) // [RULE9]
    else $error("refused start did not flag supply");
  chk_done_pulse: assert property (@(posedge mclk_i) disable iff (rst_i)
    conv_done_o |=> !conv_done_o) // [RULE11]
    else $error("done pulse longer than one cycle");
  chk_local_open: assert property (@(posedge mclk_i) disable iff (rst_i)
    !local_status_o[0]) // [RULE10]
    else $error("local open bit set");
  chk_start_run: assert property (@(posedge mclk_i) disable iff (rst_i)
    (start_ok && !cmd.swreset) |=> converting_o) // [RULE8]
    else $error("accepted start not running");
endmodule

// >>> rtl/gcr_gcall_dec.sv
// General call decoder: watches bytes from the serial front end.
// Assumes byte_valid_i is a one-cycle pulse per received byte and
// first_i marks the first byte after a start condition.
`timescale 1ns/100ps
module gcr_gcall_dec
(
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       byte_valid_i,
  input  wire logic       first_i,
  input  wire logic [7:0] byte_i,
  gcr_cmd_if.dec          cmd
);
  `include "gcr_params.svh"
  gcr_pkg::gcr_phase_t phase_q;  // Frame phase
  gcr_pkg::gcr_phase_t phase_d;
  logic                is_gc;    // Address byte is the general call
  logic                is_rst;   // Command byte is the reset code
  assign is_gc  = byte_valid_i && first_i && (byte_i == `GCR_GCALL_ADDR); // [RULE1]
  assign is_rst = byte_valid_i && !first_i && (phase_q == gcr_pkg::GCR_GC_ADDR)
                  && (byte_i == `GCR_CMD_SWRESET); // [RULE3]
  // Next phase: any new first byte restarts decoding
  always_comb
  begin
    phase_d = phase_q;
    if (byte_valid_i)
    begin
      if (is_gc)
        phase_d = gcr_pkg::GCR_GC_ADDR; // Evaluate next byte [RULE2]
      else if (first_i)
        phase_d = gcr_pkg::GCR_IDLE;
      else if (phase_q == gcr_pkg::GCR_GC_ADDR)
        phase_d = gcr_pkg::GCR_GC_CMD; // Other codes dropped [RULE6]
    end
  end
  // Phase register and acknowledge of general call bytes
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      phase_q     <= gcr_pkg::GCR_IDLE;
      cmd.ack     <= 1'b0;
      cmd.swreset <= 1'b0;
    end
    else
    begin
      phase_q     <= phase_d;
      if (byte_valid_i)
        cmd.ack   <= is_gc || (!first_i && (phase_q == gcr_pkg::GCR_GC_ADDR)); // New START drops it [RULE1]
      cmd.swreset <= is_rst; // Fires on the same edge as the ack decision [RULE11]
    end
  end
endmodule

// >>> rtl/gcr_params.svh
// Constants for the general call reset and supply check block.
// Assumes inclusion by bare name from rtl/ files only.
`ifndef GCR_PARAMS_SVH
`define GCR_PARAMS_SVH
`define GCR_GCALL_ADDR      8'h00
`define GCR_CMD_SWRESET     8'h06
`define GCR_SUPPLY_BIT      1
`define GCR_OPEN_BIT        0
`define GCR_RESULT_RST      8'h00
`define GCR_CONV_CYCLES     16'h0040
`endif

// >>> rtl/gcr_pkg.sv
// Types shared by the general call reset block.
// Assumes the params header is used alongside for numbers.
package gcr_pkg;
  // Phase of the bus frame decoder
  typedef enum logic [1:0] {
    GCR_IDLE,
    GCR_GC_ADDR,
    GCR_GC_CMD
  } gcr_phase_t;
  // Conversion engine state
  typedef enum logic [1:0] {
    GCR_CONV_IDLE,
    GCR_CONV_RUN
  } gcr_conv_t;
endpackage

// >>> testbench/gcr_master_model.sv
// Behavioural two-wire master handing whole received bytes to the core.
// Assumes the core samples its byte inputs on the rising edge of mclk_i.
`timescale 1ns/100ps
module gcr_master_model
(
  input  wire logic       mclk_i,
  output logic            byte_valid_o,
  output logic            first_o,
  output logic [7:0]      byte_o
);
  // Idle lines carry no byte
  initial
  begin
    byte_valid_o = 1'b0;
    first_o      = 1'b0;
    byte_o       = 8'hFF;
  end
  // One byte per call, launched just after an edge, held for one edge
  task automatic put(input logic f, input logic [7:0] b);
    @(posedge mclk_i);
    #1;
    byte_valid_o = 1'b1;
    first_o      = f;
    byte_o       = b;
    @(posedge mclk_i);
    #1;
    byte_valid_o = 1'b0;
    byte_o       = ~b; // Stale data must not look valid
  endtask
endmodule

// >>> testbench/tb_general_call_reset_and_supply_check.sv
// Self-checking bench for the general call reset and supply check core.
// Assumes the master model drives the byte side; bench drives the rest.
`timescale 1ns/100ps
module tb_general_call_reset_and_supply_check;
  logic mclk_i, rst_i, supply_ok_i, sensor_open_i, conv_start_i;
  logic byte_valid_i, first_i, gc_ack_o, swreset_o, converting_o, conv_done_o;
  logic [7:0] byte_i, b;
  logic [1:0] local_status_o, remote_status_o;
  logic [3:0] exp_q[$]; // Expected {remote, local} status per result
  logic was_conv = 1'b0; // Conversion running one cycle ago
  int n_errors = 0;
  int tests_run = 0;
  gcr_master_model u_mst (.mclk_i(mclk_i), .byte_valid_o(byte_valid_i), .first_o(first_i), .byte_o(byte_i));
  gcr_core u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .byte_valid_i(byte_valid_i), .first_i(first_i),
    .byte_i(byte_i), .supply_ok_i(supply_ok_i), .sensor_open_i(sensor_open_i), .conv_start_i(conv_start_i),
    .gc_ack_o(gc_ack_o), .swreset_o(swreset_o), .converting_o(converting_o), .conv_done_o(conv_done_o),
    .local_status_o(local_status_o), .remote_status_o(remote_status_o));
  // 50 MHz clock
  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  task automatic stop_test();
    if (n_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // Start pulse; converting shows on the taking edge, checked one edge later
  task automatic conv(input logic [3:0] run);
    conv_start_i = 1'b1;
    cyc(1);
    conv_start_i = 1'b0;
    cyc(1);
    chk("converting", run, {3'h0, converting_o});
  endtask
  // Bounded wait for the attempt to end
  task automatic wait_done();
    int k;
    k = 0;
    while (converting_o !== 1'b0 && k < 200)
    begin
      cyc(1);
      k++;
    end
    if (k >= 200)
    begin
      n_errors++;
      stop_test();
    end
    cyc(2);
  endtask
  // Result watcher: every done or reset pulse takes the oldest note
  always @(posedge mclk_i)
  begin
    #2;
    if (swreset_o === 1'b1 || (conv_done_o === 1'b1 && was_conv))
    begin
      if (exp_q.size() == 0)
        chk("unexpected result", 4'h0, 4'hF);
      else
        chk("status", exp_q.pop_front(), {remote_status_o, local_status_o});
    end
    was_conv = (converting_o === 1'b1);
  end
  initial
  begin
    void'($urandom(32'h6149));
    {rst_i, supply_ok_i, sensor_open_i, conv_start_i} = 4'hC;
    cyc(3);
    rst_i = 1'b0;
    cyc(6);
    // A clean conversion, then an open sensor
    for (int i = 0; i < 2; i++)
    begin
      sensor_open_i = i[0];
      exp_q.push_back({1'b0, i[0], 2'h0});
      conv(4'h1);
      wait_done();
    end
    sensor_open_i = 1'b0;
    // Bad supply refuses the start and flags both results
    supply_ok_i = 1'b0;
    cyc(6);
    conv(4'h0);
    chk("refused status", 4'hE, {remote_status_o, local_status_o});
    // Good supply again clears the flag at the next attempt end
    supply_ok_i = 1'b1;
    cyc(6);
    exp_q.push_back(4'h0);
    conv(4'h1);
    wait_done();
    // Supply lost mid conversion
    conv(4'h1);
    cyc(10);
    supply_ok_i = 1'b0;
    exp_q.push_back(4'hA);
    wait_done();
    supply_ok_i = 1'b1;
    cyc(6);
    // A random non-zero address is not the general call
    u_mst.put(1'b1, 8'($urandom_range(1, 255)));
    cyc(2);
    chk("no ack", 4'h0, {3'h0, gc_ack_o});
    // Other command during a conversion changes nothing
    conv(4'h1);
    u_mst.put(1'b1, 8'h00);
    cyc(2);
    chk("gc ack", 4'h1, {3'h0, gc_ack_o});
    b = 8'($urandom_range(0, 255));
    u_mst.put(1'b0, (b == 8'h06) ? 8'h07 : b);
    cyc(2);
    chk("still running", 4'h1, {3'h0, converting_o});
    exp_q.push_back(4'h0);
    wait_done();
    // Flag a refusal first so the reset has a status to clear
    supply_ok_i = 1'b0;
    cyc(6);
    conv(4'h0);
    chk("refused again", 4'hA, {remote_status_o, local_status_o});
    supply_ok_i = 1'b1;
    cyc(6);
    // Reset command aborts an open-sensor conversion
    sensor_open_i = 1'b1;
    conv(4'h1);
    u_mst.put(1'b1, 8'h00);
    exp_q.push_back(4'h0);
    u_mst.put(1'b0, 8'h06);
    cyc(4);
    chk("aborted", 4'h0, {3'h0, converting_o});
    cyc(80);
    chk("queue empty", 4'h0, 4'(exp_q.size()));
    stop_test();
  end
endmodule
